//--- bus_strobe_pkg.sv
// constants shared by the external bus strobe and wait-state logic
package bus_strobe_pkg;
    // ------------------------------------------------------------
    // configuration field positions
    // ------------------------------------------------------------
    localparam int CFG_WIDTH = 8;
    localparam int CFG_WRITE_STYLE_BIT = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ------------------------------------------------------------
    // bus timing
    // ------------------------------------------------------------
    localparam int WAIT_WIDTH = 2;
    localparam logic [1:0] WAIT_ZERO = 2'h0;
    localparam int SYNC_STAGES = 3;
    // ------------------------------------------------------------
    // cycle states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } cycle_state_t;
endpackage : bus_strobe_pkg

//--- ready_sync.sv
// three-stage synchroniser for the external ready pin
`timescale 1ns/100ps
`default_nettype none
module ready_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // pin side
    input wire logic pin_in,
    // synchronised level
    output logic level_out
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // ------------------------------------------------------------
    // shift chain; the level only moves once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        next_stage = {stage[1:0], pin_in};
        next_level = (stage[2] == stage[1]) ? stage[2] : level_out;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            stage <= 3'h0;
            level_out <= 1'b0;
        end else begin
            stage <= next_stage;
            level_out <= next_level;
        end
    end
endmodule : ready_sync
`default_nettype wire

//--- external_bus_strobe_ready.sv
// external bus strobe generation with programmed and ready-driven wait states
`timescale 1ns/100ps
`default_nettype none
// Operation
// - ready input adds waits beyond programmed ones
// - ready high: only programmed waits inserted
// - internal accesses ignore ready entirely
// - combined write strobe only on external writes
// - config bit two selects write pin function
// - 16-bit: high strobe on high/word writes
// - 8-bit: high strobe on every write
// - config bit selects byte-high or high strobe
// - read strobe only on external reads
// - low strobe on low/word or 8-bit writes
module external_bus_strobe_ready
    import bus_strobe_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_B_IN,
    // configuration
    input wire logic [CFG_WIDTH-1:0] CHIP_CONFIG_REG_ZERO_IN,
    // cpu access request
    input wire logic REQ_VALID_IN,
    input wire logic REQ_WRITE_IN,
    input wire logic REQ_EXTERNAL_IN,
    input wire logic REQ_BUS16_IN,
    input wire logic [1:0] REQ_BYTE_EN_IN,
    input wire logic [WAIT_WIDTH-1:0] REQ_WAITS_IN,
    // cpu handshake
    output logic REQ_READY_OUT,
    output logic DONE_OUT,
    // external bus pins
    input wire logic READY_IN,
    output logic RD_N_OUT,
    output logic WR_LOW_PIN_N_OUT,
    output logic WR_HIGH_PIN_N_OUT
);
    // ------------------------------------------------------------
    // ready synchroniser
    // ------------------------------------------------------------
    logic ready_level;

    ready_sync u_ready_sync (
        .clk_in(CLK_IN),
        .rst_b_in(RST_B_IN),
        .pin_in(READY_IN),
        .level_out(ready_level)
    );

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the style bit must sit inside the configuration word, and the
    // wait counter needs at least one bit to count the programmed waits
    if (CFG_WRITE_STYLE_BIT >= CFG_WIDTH) begin : g_bad_style_bit
        $error("write style bit outside the configuration word");
    end
    if (WAIT_WIDTH < 1) begin : g_bad_wait_width
        $error("wait counter width must be at least one");
    end

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    function automatic logic [2:0] strobe_decode(input logic wr, input logic ext,
                                                 input logic bus16, input logic [1:0] be,
                                                 input logic combined);
        logic rd_n;
        logic lo_n;
        logic hi_n;
        rd_n = !(ext && !wr);
        if (combined) begin
            lo_n = !(ext && wr);
            hi_n = !(ext && bus16 && be[1]);
        end else begin
            lo_n = !(ext && wr && (!bus16 || be[0]));
            hi_n = !(ext && wr && (!bus16 || be[1]));
        end
        return {rd_n, lo_n, hi_n};
    endfunction : strobe_decode

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    cycle_state_t state;
    cycle_state_t next_state;
    logic [WAIT_WIDTH-1:0] wait_left;
    logic [WAIT_WIDTH-1:0] next_wait_left;
    logic cur_ext;
    logic next_cur_ext;
    logic [2:0] strobes;
    logic [2:0] next_strobes;

    assign REQ_READY_OUT = (state == ST_IDLE);
    // write style of the live configuration, and a request taken on this edge
    logic style_combined;
    logic req_taken;
    assign style_combined = CHIP_CONFIG_REG_ZERO_IN[CFG_WRITE_STYLE_BIT];
    assign req_taken = REQ_VALID_IN && REQ_READY_OUT;

    always_comb begin
        next_state = state;
        next_wait_left = wait_left;
        next_cur_ext = cur_ext;
        next_strobes = strobes;
        unique case (state)
            ST_IDLE: begin
                if (REQ_VALID_IN) begin
                    next_cur_ext = REQ_EXTERNAL_IN;
                    next_wait_left = REQ_WAITS_IN;
                    next_strobes = strobe_decode(REQ_WRITE_IN, REQ_EXTERNAL_IN, REQ_BUS16_IN,
                        REQ_BYTE_EN_IN, style_combined);
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                // programmed waits run first; ready only extends past them
                if (wait_left != WAIT_ZERO) begin
                    next_wait_left = wait_left - 2'h1;
                end else if (cur_ext && !ready_level) begin
                    next_state = ST_WAIT;
                end else begin
                    next_state = ST_DONE;
                    next_strobes = 3'h7;
                end
            end
            ST_WAIT: begin
                if (ready_level) begin
                    next_state = ST_DONE;
                    next_strobes = 3'h7;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_B_IN) begin
            state <= ST_IDLE;
            wait_left <= WAIT_ZERO;
            cur_ext <= 1'b0;
            strobes <= 3'h7;
        end else begin
            state <= next_state;
            wait_left <= next_wait_left;
            cur_ext <= next_cur_ext;
            strobes <= next_strobes;
        end
    end

    assign DONE_OUT = (state == ST_DONE);
    assign RD_N_OUT = strobes[2];
    assign WR_LOW_PIN_N_OUT = strobes[1];
    assign WR_HIGH_PIN_N_OUT = strobes[0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    a_internal_no_wait: assert property (
        (state == ST_STROBE && !cur_ext && wait_left == WAIT_ZERO) |=> state == ST_DONE)
        else $error("internal cycle stretched");
    a_ready_low_holds: assert property (
        (state == ST_WAIT && !ready_level) |=> state == ST_WAIT && $stable(strobes))
        else $error("wait released early");
    a_ready_high_ends: assert property (
        (state == ST_WAIT && ready_level) |=> state == ST_DONE)
        else $error("wait not ended");
    a_ready_high_normal: assert property (
        (state == ST_STROBE && wait_left == WAIT_ZERO && ready_level) |=> state == ST_DONE)
        else $error("ready high cycle stretched");
    a_waits_counted: assert property (
        (state == ST_STROBE && wait_left == 2'h2) |=> state == ST_STROBE ##1 state == ST_STROBE)
        else $error("waits cut");
    a_read_external: assert property (
        !RD_N_OUT |-> cur_ext)
        else $error("read strobe internal");
    a_write_external: assert property (
        !WR_LOW_PIN_N_OUT |-> cur_ext && RD_N_OUT)
        else $error("write strobe bad");
    a_internal_quiet: assert property (
        (req_taken && !REQ_EXTERNAL_IN) |=> RD_N_OUT && WR_LOW_PIN_N_OUT && WR_HIGH_PIN_N_OUT)
        else $error("strobe on internal access");
    a_combined_write: assert property (
        (req_taken && REQ_EXTERNAL_IN && REQ_WRITE_IN && style_combined) |=> !WR_LOW_PIN_N_OUT)
        else $error("combined write missing");
    a_low_separate: assert property (
        (req_taken && REQ_EXTERNAL_IN && REQ_WRITE_IN && !style_combined
        && (!REQ_BUS16_IN || REQ_BYTE_EN_IN[0])) |=> !WR_LOW_PIN_N_OUT)
        else $error("low write strobe missing");
    a_high_8bit: assert property (
        (req_taken && REQ_EXTERNAL_IN && REQ_WRITE_IN && !style_combined && !REQ_BUS16_IN)
        |=> !WR_HIGH_PIN_N_OUT && !WR_LOW_PIN_N_OUT) else $error("8-bit strobes");
    a_high_word: assert property (
        (req_taken && REQ_EXTERNAL_IN && REQ_WRITE_IN && !style_combined && REQ_BUS16_IN
        && REQ_BYTE_EN_IN[1]) |=> !WR_HIGH_PIN_N_OUT) else $error("high write strobe missing");
    a_high_lowonly: assert property (
        (req_taken && REQ_WRITE_IN && REQ_BUS16_IN && REQ_BYTE_EN_IN == 2'h1 && !style_combined)
        |=> WR_HIGH_PIN_N_OUT) else $error("high strobe on low write");
    a_upper_enable: assert property (
        (req_taken && REQ_EXTERNAL_IN && REQ_BUS16_IN && REQ_BYTE_EN_IN[1] && style_combined)
        |=> !WR_HIGH_PIN_N_OUT) else $error("byte-high enable missing");
    a_upper_idle: assert property (
        (req_taken && style_combined && !(REQ_EXTERNAL_IN && REQ_BUS16_IN && REQ_BYTE_EN_IN[1]))
        |=> WR_HIGH_PIN_N_OUT) else $error("byte-high enable on unused lane");
    a_done_pulse: assert property (
        DONE_OUT |=> !DONE_OUT && REQ_READY_OUT)
        else $error("done longer than one cycle");
    a_strobe_release: assert property (
        DONE_OUT |-> RD_N_OUT && WR_LOW_PIN_N_OUT && WR_HIGH_PIN_N_OUT)
        else $error("strobe held past the cycle");

    c_ext_read: cover property (state == ST_STROBE && !RD_N_OUT);
    c_ready_wait: cover property (state == ST_WAIT ##1 state == ST_WAIT);
    c_word_write: cover property (!WR_LOW_PIN_N_OUT && !WR_HIGH_PIN_N_OUT);
    c_internal: cover property (state == ST_STROBE && !cur_ext);
    c_upper_read: cover property (!RD_N_OUT && !WR_HIGH_PIN_N_OUT);
endmodule : external_bus_strobe_ready
`default_nettype wire

//--- slow_memory_model.sv
// external memory model that stretches bus cycles through the ready pin
`timescale 1ns/100ps
`default_nettype none
module slow_memory_model (
    // clock
    input wire logic clk_in,
    // bus side
    input wire logic strobe_n_in,
    input wire logic [3:0] stall_in,
    // ready pin
    output logic ready_out
);
    logic [3:0] count = 4'h0;
    always @(posedge clk_in) begin
        count <= strobe_n_in ? 4'h0 : (count == 4'hF ? count : count + 4'h1);
    end
    // a slow part keeps ready low while idle too, so the synchroniser sees it in time
    assign ready_out = count >= stall_in;
endmodule : slow_memory_model
`default_nettype wire

//--- external_bus_strobe_ready_test.sv
// self-checking bench for the external bus strobe and wait-state logic
`timescale 1ns/100ps
`default_nettype none
module external_bus_strobe_ready_test;
    import bus_strobe_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] cfg = 8'h00;
    logic valid = 1'b0, wr = 1'b0, ext = 1'b0, b16 = 1'b0;
    logic [1:0] be = 2'h1;
    logic [1:0] waits = 2'h0;
    logic [3:0] stall = 4'h0;
    logic rdy_req, done, ready, rd_n, wl_n, wh_n;
    int errors = 0, comparisons = 0, cycles = 0, seed = 74956;
    external_bus_strobe_ready external_bus_strobe_ready_inst (.CLK_IN(clk), .RST_B_IN(rst_b),
        .CHIP_CONFIG_REG_ZERO_IN(cfg), .REQ_VALID_IN(valid), .REQ_WRITE_IN(wr),
        .REQ_EXTERNAL_IN(ext), .REQ_BUS16_IN(b16), .REQ_BYTE_EN_IN(be), .REQ_WAITS_IN(waits),
        .REQ_READY_OUT(rdy_req), .DONE_OUT(done), .READY_IN(ready), .RD_N_OUT(rd_n),
        .WR_LOW_PIN_N_OUT(wl_n), .WR_HIGH_PIN_N_OUT(wh_n));
    slow_memory_model slow_memory_model_inst (.clk_in(clk), .strobe_n_in(rd_n & wl_n & wh_n),
        .stall_in(stall), .ready_out(ready));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // outputs while reset holds: no strobe driven, ready for a request
    task automatic idle_check();
        check({rdy_req, rd_n, wl_n, wh_n}, 4'hF);
        check({3'h0, done}, 4'h0);
    endtask : idle_check
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    // expected {read, low pin, high pin}, all active low
    function automatic logic [2:0] expect_pins();
        logic w;
        logic c;
        w = ext & wr;
        c = cfg[CFG_WRITE_STYLE_BIT];
        return {~(ext & ~wr),
            ~(w & (c | ~b16 | be[0])),
            ~(c ? ext & b16 & be[1] : w & (~b16 | be[1]))};
    endfunction : expect_pins
    // valid stays high to the end, so a busy design must refuse the repeat
    task automatic access();
        int k;
        int lo;
        int hi;
        logic [2:0] exp;
        exp = expect_pins();
        lo = 2 + waits;
        hi = lo;
        if (ext && stall != 4'h0) begin
            lo = lo > stall + 2 ? lo : stall + 2;
            hi = hi > stall + 7 ? hi : stall + 7;
        end
        valid = 1'b1;
        while (rdy_req !== 1'b1) @(negedge clk);
        @(negedge clk);
        k = 1;
        while (done !== 1'b1 && k <= hi) begin
            check({rdy_req, rd_n, wl_n, wh_n}, {1'b0, exp});
            @(negedge clk);
            k++;
        end
        check({done, rd_n, wl_n, wh_n}, 4'hF);
        check({3'h0, k >= lo && k <= hi}, 4'h1);
    endtask : access
    initial begin
        logic [31:0] r;
        logic [3:0] last;
        last = 4'h0;
        repeat (20) @(negedge clk);
        idle_check();
        rst_b = 1'b1;
        // the ready synchroniser restarts low: let it fill before the first request
        repeat (5) @(negedge clk);
        for (int i = 0; i < 120; i++) begin
            r = $random(seed);
            stall = r[13] ? r[11:8] : 4'h0;
            // ready lags through the synchroniser, so a slow part must be seen low again
            if (stall != last || stall != 4'h0) begin
                valid = 1'b0;
                repeat (5) @(negedge clk);
            end
            last = stall;
            cfg = r[7:0];
            wr = r[16];
            ext = r[17] | r[18];
            b16 = r[19];
            be = r[21:20] == 2'h0 ? 2'h3 : r[21:20];
            waits = r[23:22];
            access();
        end
        // reset in the middle of a stretched external read
        valid = 1'b0;
        stall = 4'h3;
        repeat (5) @(negedge clk);
        cfg = 8'h00;
        wr = 1'b0;
        ext = 1'b1;
        b16 = 1'b1;
        be = 2'h3;
        waits = 2'h3;
        valid = 1'b1;
        @(negedge clk);
        check({rdy_req, rd_n, wl_n, wh_n}, 4'h3);
        rst_b = 1'b0;
        valid = 1'b0;
        @(negedge clk);
        idle_check();
        rst_b = 1'b1;
        repeat (5) @(negedge clk);
        access();
        valid = 1'b0;
        complete_run();
    end
endmodule : external_bus_strobe_ready_test
`default_nettype wire
